// ===== pcs_core.sv
// program counter sequencing, return stack and indirect addressing
//
// Overview of operation
// - thirteen bit program counter, low byte readable and writable.
// - upper counter bits never written directly, only via the latch, jump literal, stack, vector or increment carry.
// - any reset clears the whole program counter.
// - writing the low byte loads all five upper bits from the latch.
// - call or jump takes only latch bits four and three on top.
// - eight entry thirteen bit stack, pointer hidden from software.
// - call or interrupt vectoring pushes the program counter.
// - return, return literal and return from interrupt pop the stack.
// - push and pop never alter the high latch.
// - stack is circular, ninth push overwrites the first.
// - no overflow or underflow indication exists.
// - indirect port is no register, it accesses the pointed location.
// - pointer at the indirect port itself reads back zero.
// - pointer at the indirect port itself writes nothing.
// - nine bit indirect address from pointer and page select.
`timescale 1ns/100ps
`default_nettype none
module pcs_core
    import pcs_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire pcs_seq_req_s seq_i,
    input wire logic latch_we_i,
    input wire logic [HIGH_W-1:0] latch_wdata_i,
    input wire logic ptr_we_i,
    input wire logic [7:0] ptr_wdata_i,
    input wire logic page_select_bit_i,
    input wire pcs_ind_req_s ind_i,
    input wire logic [7:0] ram_rdata_i,
    output logic [PC_W-1:0] pc_o,
    output logic [LOW_W-1:0] pc_low_byte_o,
    output logic [HIGH_W-1:0] pc_high_latch_o,
    output logic [7:0] file_pointer_o,
    output logic [IND_ADDR_W-1:0] ind_addr_o,
    output logic ram_we_o,
    output logic [7:0] ram_wdata_o,
    output logic ram_re_o,
    output logic ind_rdata_valid_o,
    output logic [7:0] ind_rdata_o,
    output logic pop_pending_o
);
    if (DEPTH != STACK_DEPTH) begin : g_bad_depth
        $error("stack depth is fixed by the pointer width");
    end

    function automatic logic [SP_W-1:0] sp_step(input logic [SP_W-1:0] sp, input logic up);
        sp_step = up ? SP_W'(sp + 1'b1) : SP_W'(sp - 1'b1);
    endfunction : sp_step

    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] pc_next;
    logic [HIGH_W-1:0] pc_high_latch;
    logic [HIGH_W-1:0] latch_next;
    logic [7:0] file_pointer_reg;
    logic [7:0] ptr_next;
    logic [SP_W-1:0] sp_reg;
    logic [SP_W-1:0] sp_next;
    logic pop_wait_reg;
    logic [IND_ADDR_W-1:0] ind_addr_reg;
    logic ram_we_reg;
    logic ram_re_reg;
    logic [7:0] ram_wdata_reg;
    logic ind_rd_pend_reg;
    logic ind_rd_self_reg;
    logic ind_valid_reg;
    logic [7:0] ind_rdata_reg;

    pcs_stack_op_e stack_op;
    wire logic [PC_W-1:0] stack_rdata;
    wire logic [PC_W-1:0] pc_inc = PC_W'(pc_reg + 1'b1);

    wire logic do_push = seq_i.call | seq_i.irq_vector;
    wire logic do_pop = seq_i.ret & ~pop_wait_reg;
    // pop reads the entry below the pointer
    wire logic [SP_W-1:0] pop_addr = sp_step(sp_reg, 1'b0);
    // only latch bits four and three on top
    wire logic [PC_W-1:0] jump_target = {pc_high_latch[HIGH_W-1:JUMP_TOP_POS], seq_i.target};
    // whole latch into the upper bits
    wire logic [PC_W-1:0] low_write_target = {pc_high_latch, seq_i.low_data};

    assign stack_op = do_push ? PCS_OP_PUSH : (do_pop ? PCS_OP_POP : PCS_OP_NONE);
    wire logic stack_we = (stack_op == PCS_OP_PUSH);
    // vector saves the address not yet run, call the next one
    wire logic [PC_W-1:0] push_data = seq_i.irq_vector ? pc_reg : pc_inc;

    pcs_stack_mem #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(PC_W),
        .AW(SP_W)
    ) u_stack (
        .ref_clk_i(ref_clk_i),
        .wr_en_i(stack_we),
        .wr_addr_i(sp_reg),
        .wr_data_i(push_data),
        .rd_addr_i(pop_addr),
        .rd_data_o(stack_rdata)
    );

    // pop takes two cycles since stack read data is registered
    always_comb begin
        pc_next = pc_reg;
        sp_next = sp_reg;
        case (stack_op)
            PCS_OP_PUSH: begin
                sp_next = sp_step(sp_reg, 1'b1);
                pc_next = seq_i.irq_vector ? seq_i.vector_addr : jump_target;
            end
            PCS_OP_POP: begin
                sp_next = pop_addr;
            end
            PCS_OP_NONE: begin
                if (pop_wait_reg) begin
                    pc_next = stack_rdata;
                end else if (seq_i.low_write) begin
                    pc_next = low_write_target;
                end else if (seq_i.jump) begin
                    pc_next = jump_target;
                end else if (seq_i.advance) begin
                    pc_next = pc_inc;
                end
            end
            default: begin
                pc_next = pc_reg;
                sp_next = sp_reg;
            end
        endcase
    end

    // latch changes only on its own write
    assign latch_next = latch_we_i ? latch_wdata_i : pc_high_latch;
    assign ptr_next = ptr_we_i ? ptr_wdata_i : file_pointer_reg;

    // page bit on top of pointer
    wire logic [IND_ADDR_W-1:0] ind_addr = {page_select_bit_i, file_pointer_reg};
    // pointer aimed at the port itself
    wire logic ind_self = (file_pointer_reg == IND_PORT_ADDR);
    // accesses go to the pointed location
    wire logic ram_we_next = ind_i.valid & ind_i.write & ~ind_self;
    wire logic ram_re_next = ind_i.valid & ~ind_i.write;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pc_reg <= PC_RESET;
        end else begin
            // upper bits only via pc_next paths
            pc_reg <= pc_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sp_reg <= SP_RESET;
        end else begin
            sp_reg <= sp_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pc_high_latch <= LATCH_RESET;
        end else begin
            pc_high_latch <= latch_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            file_pointer_reg <= ZERO_BYTE;
        end else begin
            file_pointer_reg <= ptr_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pop_wait_reg <= 1'b0;
        end else begin
            pop_wait_reg <= do_pop;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ind_addr_reg <= '0;
        end else begin
            ind_addr_reg <= ind_addr;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ram_we_reg <= 1'b0;
        end else begin
            ram_we_reg <= ram_we_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ram_re_reg <= 1'b0;
        end else begin
            ram_re_reg <= ram_re_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ram_wdata_reg <= ZERO_BYTE;
        end else begin
            ram_wdata_reg <= ind_i.wdata;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ind_rd_pend_reg <= 1'b0;
        end else begin
            ind_rd_pend_reg <= ram_re_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ind_rd_self_reg <= 1'b0;
        end else begin
            ind_rd_self_reg <= ind_self;
        end
    end

    // read data arrives one cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ind_valid_reg <= 1'b0;
        end else begin
            ind_valid_reg <= ind_rd_pend_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ind_rdata_reg <= ZERO_BYTE;
        end else begin
            ind_rdata_reg <= ind_rd_self_reg ? ZERO_BYTE : ram_rdata_i;
        end
    end

    assign pc_low_byte_o = pc_reg[LOW_W-1:0];
    assign pc_o = pc_reg;
    assign pc_high_latch_o = pc_high_latch;
    assign file_pointer_o = file_pointer_reg;
    assign ind_addr_o = ind_addr_reg;
    assign ram_we_o = ram_we_reg;
    assign ram_re_o = ram_re_reg;
    assign ram_wdata_o = ram_wdata_reg;
    assign ind_rdata_valid_o = ind_valid_reg;
    assign ind_rdata_o = ind_rdata_reg;
    assign pop_pending_o = pop_wait_reg;
endmodule : pcs_core
`default_nettype wire

// ===== pcs_pkg.sv
// package for the program counter, return stack and indirect address block
package pcs_pkg;
    localparam int PC_W = 13;
    localparam int LOW_W = 8;
    localparam int HIGH_W = 5;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int IND_ADDR_W = 9;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [SP_W-1:0] SP_RESET = 3'h0;
    localparam logic [HIGH_W-1:0] LATCH_RESET = 5'h00;
    localparam logic [7:0] IND_PORT_ADDR = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int JUMP_TOP_POS = 3;
    localparam int JUMP_LIT_W = 11;

    typedef enum logic [2:0] {
        PCS_OP_NONE = 3'b001,
        PCS_OP_PUSH = 3'b010,
        PCS_OP_POP = 3'b100
    } pcs_stack_op_e;

    // one sequencing request per executed instruction
    typedef struct packed {
        logic advance;
        logic low_write;
        logic [LOW_W-1:0] low_data;
        logic jump;
        logic call;
        logic irq_vector;
        logic ret;
        logic [JUMP_LIT_W-1:0] target;
        logic [PC_W-1:0] vector_addr;
    } pcs_seq_req_s;

    // one data access through the indirect port
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] wdata;
    } pcs_ind_req_s;
endpackage : pcs_pkg

// ===== pcs_stack_mem.sv
// storage for the circular return stack, registered read
`timescale 1ns/100ps
`default_nettype none
module pcs_stack_mem
    import pcs_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = PC_W,
    parameter int AW = SP_W
) (
    input wire logic ref_clk_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);
    if (DEPTH != (1 << AW)) begin : g_bad_depth
        $error("depth must equal two to the address width");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule : pcs_stack_mem
`default_nettype wire

// ===== pcs_core_monitor.sv
// assertion checker for the sequencing and indirect address block
`timescale 1ns/100ps
`default_nettype none
module pcs_core_monitor
    import pcs_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire pcs_seq_req_s seq_i,
    input wire logic latch_we_i,
    input wire logic ptr_we_i,
    input wire logic page_select_bit_i,
    input wire pcs_ind_req_s ind_i,
    input wire logic [PC_W-1:0] pc_o,
    input wire logic [HIGH_W-1:0] pc_high_latch_o,
    input wire logic [7:0] file_pointer_o,
    input wire logic [IND_ADDR_W-1:0] ind_addr_o,
    input wire logic ram_we_o,
    input wire logic [7:0] ram_wdata_o,
    input wire logic ram_re_o,
    input wire logic ind_rdata_valid_o,
    input wire logic [7:0] ind_rdata_o,
    input wire logic pop_pending_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // stack traffic or a latch write in the same cycle would change the expected value
    wire logic quiet = !seq_i.call && !seq_i.irq_vector && !seq_i.ret && !pop_pending_o && !latch_we_i;
    wire logic ptr_zero = file_pointer_o == IND_PORT_ADDR;
    wire logic rd_req = ind_i.valid && !ind_i.write && !ptr_we_i;
    wire logic wr_req = ind_i.valid && ind_i.write && !ptr_we_i;
    property p_rst_pc; $rose(resetn_i) |-> pc_o == PC_RESET; endproperty
    a_rst_pc: assert property (p_rst_pc) else $error("pc not clear after reset");
    property p_low; seq_i.low_write && quiet |=> pc_o == {$past(pc_high_latch_o), $past(seq_i.low_data)}; endproperty
    a_low: assert property (p_low) else $error("low byte write load wrong");
    property p_jump;
        seq_i.jump && !seq_i.low_write && quiet |=> pc_o == {$past(pc_high_latch_o[4:3]), $past(seq_i.target)};
    endproperty
    a_jump: assert property (p_jump) else $error("jump load wrong");
    property p_adv;
        seq_i.advance && !seq_i.low_write && !seq_i.jump && quiet |=> pc_o == $past(pc_o) + 13'h0001;
    endproperty
    a_adv: assert property (p_adv) else $error("advance step wrong");
    property p_irq; seq_i.irq_vector && !pop_pending_o |=> pc_o == $past(seq_i.vector_addr); endproperty
    a_irq: assert property (p_irq) else $error("vector not taken");
    property p_pop; seq_i.ret && !pop_pending_o |=> pop_pending_o ##1 !pop_pending_o; endproperty
    a_pop: assert property (p_pop) else $error("pop sequence wrong");
    property p_keep; (seq_i.call || seq_i.irq_vector || seq_i.ret) && !latch_we_i |=> $stable(pc_high_latch_o); endproperty
    a_keep: assert property (p_keep) else $error("latch moved by stack op");
    property p_zrd; rd_req && ptr_zero |-> ##2 ind_rdata_valid_o && ind_rdata_o == ZERO_BYTE; endproperty
    a_zrd: assert property (p_zrd) else $error("self read not zero");
    property p_zwr; wr_req && ptr_zero |=> !ram_we_o; endproperty
    a_zwr: assert property (p_zwr) else $error("self write stored");
    property p_wr; wr_req && !ptr_zero |=> ram_we_o && ram_wdata_o == $past(ind_i.wdata); endproperty
    a_wr: assert property (p_wr) else $error("indirect write lost");
    property p_rd; rd_req && !ptr_zero |=> ram_re_o ##1 ind_rdata_valid_o; endproperty
    a_rd: assert property (p_rd) else $error("indirect read chain wrong");
    property p_addr; ind_i.valid && !ptr_we_i |=> ind_addr_o == {$past(page_select_bit_i), $past(file_pointer_o)}; endproperty
    a_addr: assert property (p_addr) else $error("indirect address wrong");
endmodule : pcs_core_monitor
`default_nettype wire

// ===== pcs_core_tb_top.sv
// self-checking testbench for the sequencing and indirect address block
`timescale 1ns/100ps
`default_nettype none
module pcs_core_tb_top
    import pcs_pkg::*;
;
    logic ref_clk_i = 1'b0, resetn_i = 1'b0, latch_we_i = 1'b0, ptr_we_i = 1'b0, page_select_bit_i = 1'b0;
    logic [4:0] latch_wdata_i = 5'h00;
    logic [7:0] ptr_wdata_i = 8'h00, ram_rdata_i = 8'h5a;
    pcs_seq_req_s seq_i = '0;
    pcs_ind_req_s ind_i = '0;
    logic [PC_W-1:0] pc_o, exp_pc;
    logic [PC_W-1:0] stk [8];
    logic [2:0] sp = 3'h0;
    logic [7:0] pc_low_byte_o, file_pointer_o, ram_wdata_o, ind_rdata_o;
    logic [4:0] pc_high_latch_o;
    logic [8:0] ind_addr_o;
    logic ram_we_o, ram_re_o, ind_rdata_valid_o, pop_pending_o;
    int fail_count = 0, n_checks = 0;
    pcs_core DUT (.ref_clk_i, .resetn_i, .seq_i, .latch_we_i, .latch_wdata_i, .ptr_we_i, .ptr_wdata_i,
        .page_select_bit_i, .ind_i, .ram_rdata_i, .pc_o, .pc_low_byte_o, .pc_high_latch_o, .file_pointer_o,
        .ind_addr_o, .ram_we_o, .ram_wdata_o, .ram_re_o, .ind_rdata_valid_o, .ind_rdata_o, .pop_pending_o);
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task automatic step(int n = 1);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : step
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic close_out();
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    // the idle cycle after each request also covers the gap a pop needs
    task automatic seq(pcs_seq_req_s r);
        seq_i = r;
        step();
        seq_i = '0;
        step();
    endtask : seq
    task automatic ind(logic w, logic [7:0] d, logic we_e, logic [7:0] rd_e);
        ind_i = '{1'b1, w, d};
        step();
        ind_i = '0;
        chk("ram_we", we_e, ram_we_o);
        chk("ram_re", !w, ram_re_o);
        chk("ind_addr", {page_select_bit_i, ptr_wdata_i}, ind_addr_o);
        if (we_e) chk("ram_wdata", d, ram_wdata_o);
        step();
        if (!w) chk("ind_rdata", {1'b1, rd_e}, {ind_rdata_valid_o, ind_rdata_o});
    endtask : ind
    task automatic t_pc();
        pcs_seq_req_s r;
        chk("pc_reset", 13'h0000, pc_o);
        latch_we_i = 1'b1;
        latch_wdata_i = 5'h15;
        step();
        latch_we_i = 1'b0;
        r = '0;
        r.low_write = 1'b1;
        r.low_data = 8'ha5;
        seq(r);
        chk("pc_low", 13'h15a5, pc_o);
        chk("low_byte", 8'ha5, pc_low_byte_o);
        // table entry lies past one low byte rollover
        latch_we_i = 1'b1;
        latch_wdata_i = 5'h16;
        step();
        latch_we_i = 1'b0;
        r = '0;
        r.low_write = 1'b1;
        r.low_data = 8'h02;
        seq(r);
        chk("pc_table", 13'h1602, pc_o);
        r = '0;
        r.jump = 1'b1;
        r.target = 11'h7ff;
        seq(r);
        chk("pc_jump", 13'h17ff, pc_o);
        r = '0;
        r.advance = 1'b1;
        seq(r);
        exp_pc = 13'h1800;
        chk("pc_advance", exp_pc, pc_o);
    endtask : t_pc
    task automatic t_stack();
        pcs_seq_req_s r;
        for (int i = 0; i < 10; i++) begin
            r = '0;
            r.call = 1'b1;
            r.target = 11'h100 + 11'(i);
            stk[sp] = exp_pc + 13'h0001;
            sp++;
            seq(r);
            exp_pc = {2'b10, r.target};
            chk("pc_call", exp_pc, pc_o);
        end
        r = '0;
        r.irq_vector = 1'b1;
        r.vector_addr = 13'h0004;
        stk[sp] = exp_pc;
        sp++;
        seq(r);
        chk("pc_irq", 13'h0004, pc_o);
        for (int i = 0; i < 9; i++) begin
            r = '0;
            r.ret = 1'b1;
            sp--;
            seq(r);
            chk("pc_pop", stk[sp], pc_o);
        end
        chk("latch", 5'h16, pc_high_latch_o);
    endtask : t_stack
    task automatic t_reset();
        resetn_i = 1'b0;
        step(2);
        resetn_i = 1'b1;
        chk("pc_rerst", 13'h0000, pc_o);
        chk("latch_rerst", 5'h00, pc_high_latch_o);
        chk("ptr_rerst", 8'h00, file_pointer_o);
        step();
        chk("pc_idle", 13'h0000, pc_o);
        chk("strobes", 2'b00, {ram_we_o, ram_re_o});
    endtask : t_reset
    task automatic t_ind();
        ptr_we_i = 1'b1;
        step();
        ptr_we_i = 1'b0;
        ind(1'b0, 8'h00, 1'b0, 8'h00);
        ind(1'b1, 8'hc3, 1'b0, 8'h00);
        ptr_we_i = 1'b1;
        ptr_wdata_i = 8'h3c;
        page_select_bit_i = 1'b1;
        step();
        ptr_we_i = 1'b0;
        chk("pointer", 8'h3c, file_pointer_o);
        ind(1'b1, 8'hc3, 1'b1, 8'h00);
        ind(1'b0, 8'h00, 1'b0, 8'h5a);
    endtask : t_ind
    initial begin
        step(6);
        resetn_i = 1'b1;
        t_pc();
        t_stack();
        t_ind();
        t_reset();
        close_out();
    end
    initial begin
        step(2000);
        fail_count++;
        close_out();
    end
endmodule : pcs_core_tb_top
bind pcs_core pcs_core_monitor u_mon (.ref_clk_i, .resetn_i, .seq_i, .latch_we_i, .ptr_we_i, .page_select_bit_i,
    .ind_i, .pc_o, .pc_high_latch_o, .file_pointer_o, .ind_addr_o, .ram_we_o, .ram_wdata_o, .ram_re_o,
    .ind_rdata_valid_o, .ind_rdata_o, .pop_pending_o);
`default_nettype wire
